// *** src/ssdbw_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module ssdbw_top
  import ssdbw_pkg::*;
(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  // straps
  input wire logic [io_addr_width-3:0] io_base_strap_in,
  input wire logic [mem_addr_width-bank_byte_bits-1:0] window_range_strap_in,
  // host io side
  input wire logic [io_addr_width-1:0] io_addr_in,
  input wire logic io_wr_in,
  input wire logic io_rd_in,
  input wire logic [7:0] io_wdata_in,
  output logic [7:0] io_rdata_out,
  output logic io_hit_out,
  // host memory side
  input wire logic [mem_addr_width-1:0] mem_addr_in,
  input wire logic mem_wr_in,
  input wire logic mem_rd_in,
  // socket side
  output ssdbw_mem_type sock_out
);
  // -----------------------------
  // helpers
  // -----------------------------
  // both low bits kept in the offset compare; the 4-byte block rides on the strap
  function automatic logic reg_hit(
    input logic [io_addr_width-1:0] a,
    input logic [io_addr_width-3:0] base,
    input logic [1:0] off
  );
    reg_hit = (a[io_addr_width-1:2] == base) && (a[1:0] == off);
  endfunction

  // one low select per code; code 00 keeps every socket dark
  function automatic logic [socket_count-1:0] socket_mask(input ssdbw_socket_type code);
    logic [socket_count-1:0] mask;
    mask = {socket_count{1'b1}};
    case (code)
      ssdbw_sock_one_type_v: begin
        mask[0] = 1'b0;
      end
      ssdbw_sock_two_type_v: begin
        mask[1] = 1'b0;
      end
      ssdbw_sock_three_type_v: begin
        mask[2] = 1'b0;
      end
      default: begin
        mask = {socket_count{1'b1}};
      end
    endcase
    socket_mask = mask;
  endfunction

  // protect flag on top of the seven bank bits
  function automatic logic [7:0] bank_image(input ssdbw_bank_type b);
    bank_image = {b.write_protect_enable, b.bank_field_bits};
  endfunction

  // fixed upper nibble, socket field, low pair reads as zero
  function automatic logic [7:0] socket_image(input ssdbw_socket_type code);
    socket_image = {socket_fixed_upper, code, 2'h0};
  endfunction

  // active-low strobe: a window hit with the command and nothing blocking it
  function automatic logic strobe_n(input logic hit, input logic cmd, input logic block);
    strobe_n = !(hit && cmd && !block);
  endfunction

  // -----------------------------
  // io decode
  // -----------------------------
  logic bank_sel;
  logic sock_sel;
  logic bank_wr;
  logic sock_wr;
  logic bank_rd;
  logic sock_rd;
  logic miss_rd;

  // straps are static, so the decode needs no register
  // writes to unmapped offsets are dropped without an answer
  always_comb begin
    bank_sel = reg_hit(io_addr_in, io_base_strap_in, bank_reg_offset);
    sock_sel = reg_hit(io_addr_in, io_base_strap_in, socket_reg_offset);
    bank_wr = io_wr_in && bank_sel;
    sock_wr = io_wr_in && sock_sel;
    bank_rd = io_rd_in && bank_sel;
    sock_rd = io_rd_in && sock_sel;
    miss_rd = io_rd_in && !bank_sel && !sock_sel;
    io_hit_out = bank_sel || sock_sel;
  end

  // -----------------------------
  // selection registers
  // -----------------------------
  ssdbw_bank_type bank_ff;
  ssdbw_bank_type nxt_bank;
  ssdbw_socket_type socket_ff;
  ssdbw_socket_type nxt_socket;

  // a write lands at its taking edge, so the very next window access sees it
  always_comb begin
    nxt_bank = bank_ff;
    nxt_socket = socket_ff;
    if (bank_wr) begin
      nxt_bank = ssdbw_bank_type'(io_wdata_in);
    end
    if (sock_wr) begin
      nxt_socket = ssdbw_socket_type'(io_wdata_in[socket_field_lsb +: 2]);
    end
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      bank_ff <= ssdbw_bank_type'(bank_reg_reset);
      socket_ff <= ssdbw_socket_type'(socket_reg_reset);
    end else begin
      bank_ff <= nxt_bank;
      socket_ff <= nxt_socket;
    end
  end

  // -----------------------------
  // read data
  // -----------------------------
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;

  // data stands until the next read, so a slow host may sample it late
  always_comb begin
    nxt_rdata = rdata_ff;
    if (bank_rd) begin
      nxt_rdata = bank_image(bank_ff);
    end else if (sock_rd) begin
      nxt_rdata = socket_image(socket_ff);
    end else if (miss_rd) begin
      nxt_rdata = 8'hff;
    end
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign io_rdata_out = rdata_ff;

  // -----------------------------
  // memory window
  // -----------------------------
  logic win_hit;
  logic rd_strobe_n;
  logic wr_strobe_n;

  // window compare kept apart so a wider strap only touches that module
  ssdbw_window_dec u_dec (
    .mem_addr_in(mem_addr_in),
    .window_range_strap_in(window_range_strap_in),
    .hit_out(win_hit)
  );

  always_comb begin
    rd_strobe_n = strobe_n(win_hit, mem_rd_in, 1'b0);
    // protect gates only the write strobe; reads go on as before
    wr_strobe_n = strobe_n(win_hit, mem_wr_in, bank_ff.write_protect_enable);
  end

  // -----------------------------
  // socket strobes
  // -----------------------------
  ssdbw_mem_type sock_ff;
  ssdbw_mem_type nxt_sock;

  // registered strobes cost a cycle but keep the socket pins glitch free
  always_comb begin
    nxt_sock.socket_sel_n = {socket_count{1'b1}};
    if (win_hit) begin
      nxt_sock.socket_sel_n = socket_mask(socket_ff);
    end
    nxt_sock.bank_field_bits = bank_ff.bank_field_bits;
    nxt_sock.offset = mem_addr_in[bank_byte_bits-1:0];
    nxt_sock.read_n = rd_strobe_n;
    nxt_sock.write_n = wr_strobe_n;
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sock_ff.socket_sel_n <= {socket_count{1'b1}};
      sock_ff.bank_field_bits <= '0;
      sock_ff.offset <= '0;
      sock_ff.write_n <= 1'b1;
      sock_ff.read_n <= 1'b1;
    end else begin
      sock_ff <= nxt_sock;
    end
  end

  assign sock_out = sock_ff;
  // bank patterns per chip size are composed by host software and pass through untouched
endmodule
`default_nettype wire

// *** src/ssdbw_pkg.sv ***
`default_nettype none
package ssdbw_pkg;
  // register offsets within the io window
  localparam logic [1:0] bank_reg_offset = 2'h0;
  localparam logic [1:0] socket_reg_offset = 2'h2;
  // bank register layout
  localparam int wpe_pos = 7;
  localparam int bank_field_width = 7;
  // socket register layout
  localparam int socket_field_lsb = 2;
  localparam logic [3:0] socket_fixed_upper = 4'h1;
  // reset values
  localparam logic [7:0] bank_reg_reset = 8'h00;
  localparam logic [1:0] socket_reg_reset = 2'h0;
  // bank geometry
  localparam int bank_byte_bits = 13;
  localparam int io_addr_width = 10;
  localparam int mem_addr_width = 20;
  localparam int socket_count = 3;

  typedef enum logic [1:0] {
    ssdbw_sock_off_type_v,
    ssdbw_sock_one_type_v,
    ssdbw_sock_two_type_v,
    ssdbw_sock_three_type_v
  } ssdbw_socket_type;

  typedef struct packed {
    logic write_protect_enable;
    logic [bank_field_width-1:0] bank_field_bits;
  } ssdbw_bank_type;

  typedef struct packed {
    logic [socket_count-1:0] socket_sel_n;
    logic [bank_field_width-1:0] bank_field_bits;
    logic [bank_byte_bits-1:0] offset;
    logic write_n;
    logic read_n;
  } ssdbw_mem_type;
endpackage
`default_nettype wire

// *** src/ssdbw_window_dec.sv ***
`timescale 1ns/1ps
`default_nettype none
module ssdbw_window_dec
  import ssdbw_pkg::*;
(
  // host memory address and straps
  input wire logic [mem_addr_width-1:0] mem_addr_in,
  input wire logic [mem_addr_width-bank_byte_bits-1:0] window_range_strap_in,
  // hit
  output logic hit_out
);
  // -----------------------------
  // window compare
  // -----------------------------
  always_comb begin
    hit_out = (mem_addr_in[mem_addr_width-1:bank_byte_bits] == window_range_strap_in);
  end
endmodule
`default_nettype wire

// *** verification/ssdbw_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module ssdbw_host (
  // host bus, strobes as {write, read}
  input wire logic clk_in,
  output logic [1:0] io_op_out,
  output logic [9:0] io_a_out,
  output logic [7:0] io_d_out,
  output logic [1:0] mem_op_out,
  output logic [19:0] mem_a_out
);
  // changed at a falling edge, held over exactly one taking edge
  task automatic go(input logic [1:0] o, input logic [9:0] a, input logic [7:0] d, input logic [1:0] m,
                    input logic [19:0] ma);
    {io_op_out, io_a_out, io_d_out, mem_op_out, mem_a_out} <= {o, a, d, m, ma};
    @(negedge clk_in);
  endtask
endmodule
`default_nettype wire

// *** verification/ssdbw_top_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module ssdbw_top_properties
  import ssdbw_pkg::*;
(
  // watched ports
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] io_base_strap_in,
  input wire logic [6:0] window_range_strap_in,
  input wire logic [9:0] io_addr_in,
  input wire logic io_wr_in,
  input wire logic io_rd_in,
  input wire logic [7:0] io_wdata_in,
  input wire logic [7:0] io_rdata_out,
  input wire logic io_hit_out,
  input wire logic [19:0] mem_addr_in,
  input wire logic mem_wr_in,
  input wire logic mem_rd_in,
  input wire ssdbw_mem_type sock_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  AST_DECODE: assert property (
    io_hit_out == (io_addr_in[9:2] == io_base_strap_in && !io_addr_in[0])) else $error("decode");
  AST_UNMAPPED: assert property (
    io_rd_in && !io_hit_out |=> io_rdata_out == 8'hff) else $error("unmapped");
  AST_SOCK_RD: assert property (
    io_rd_in && io_hit_out && io_addr_in[1] |=> io_rdata_out[7:4] == 4'h1 && io_rdata_out[1:0] == 2'h0)
    else $error("socket read");
  AST_BANK_RD: assert property (
    io_wr_in && io_hit_out && !io_addr_in[1] ##1 io_rd_in && io_addr_in == $past(io_addr_in)
    |=> io_rdata_out == $past(io_wdata_in, 2)) else $error("bank read");
  AST_NEXT: assert property (
    io_wr_in && io_hit_out && !io_addr_in[1] ##1 mem_wr_in
    |=> sock_out.bank_field_bits == $past(io_wdata_in[6:0], 2)) else $error("bank late");
  AST_PROTECT: assert property (
    io_wr_in && io_hit_out && !io_addr_in[1] && io_wdata_in[7] ##1 mem_wr_in |=> sock_out.write_n)
    else $error("protect");
  AST_ONE_SOCKET: assert property (
    $countones(~sock_out.socket_sel_n) < 2) else $error("sockets");
  AST_OFFSET: assert property (
    !sock_out.read_n |-> sock_out.offset == $past(mem_addr_in[12:0])
    && $past(mem_addr_in[19:13]) == window_range_strap_in) else $error("offset");
endmodule
bind ssdbw_top ssdbw_top_properties chk (
  .core_clk_in(core_clk_in),
  .sys_rst_in(sys_rst_in),
  .io_base_strap_in(io_base_strap_in),
  .window_range_strap_in(window_range_strap_in),
  .io_addr_in(io_addr_in),
  .io_wr_in(io_wr_in),
  .io_rd_in(io_rd_in),
  .io_wdata_in(io_wdata_in),
  .io_rdata_out(io_rdata_out),
  .io_hit_out(io_hit_out),
  .mem_addr_in(mem_addr_in),
  .mem_wr_in(mem_wr_in),
  .mem_rd_in(mem_rd_in),
  .sock_out(sock_out)
);
`default_nettype wire

// *** verification/test_ssdbw_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fails++; $display("CHECK FAILED %0t %h %h", $time, a, b); end end
module test_ssdbw_top;
  import ssdbw_pkg::*;
  logic core_clk_in = 0, sys_rst_in = 1, io_wr_in, io_rd_in, io_hit_out, mem_wr_in, mem_rd_in;
  logic [7:0] io_base_strap_in = 8'h84, io_wdata_in, io_rdata_out;
  logic [6:0] window_range_strap_in = 7'h68;
  logic [9:0] io_addr_in;
  logic [19:0] mem_addr_in;
  ssdbw_mem_type sock_out;
  int fails = 0, checks_done = 0, n = 0;
  ssdbw_host h (.clk_in(core_clk_in), .io_op_out({io_wr_in, io_rd_in}), .io_a_out(io_addr_in),
    .io_d_out(io_wdata_in), .mem_op_out({mem_wr_in, mem_rd_in}), .mem_a_out(mem_addr_in));
  ssdbw_top dut (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .io_base_strap_in(io_base_strap_in),
    .window_range_strap_in(window_range_strap_in),
    .io_addr_in(io_addr_in),
    .io_wr_in(io_wr_in),
    .io_rd_in(io_rd_in),
    .io_wdata_in(io_wdata_in),
    .io_rdata_out(io_rdata_out),
    .io_hit_out(io_hit_out),
    .mem_addr_in(mem_addr_in),
    .mem_wr_in(mem_wr_in),
    .mem_rd_in(mem_rd_in),
    .sock_out(sock_out)
  );
  initial begin
    forever #50 core_clk_in = ~core_clk_in;
  end
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    h.go(2'b10, a, d, 2'b00, 20'h0);
  endtask
  // data is read a cycle late since it stands until the next read
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    h.go(2'b01, a, 8'h0, 2'b00, 20'h0);
    h.go(2'b00, ~a, 8'hff, 2'b00, 20'h0);
    `CHK(io_rdata_out, e)
  endtask
  task automatic acc(input logic [1:0] m, input logic [19:0] a, input logic [11:0] e);
    h.go(2'b00, 10'h0, 8'h0, m, a);
    `CHK({sock_out.socket_sel_n, sock_out.write_n, sock_out.read_n, sock_out.bank_field_bits}, e)
    h.go(2'b00, 10'h0, 8'h0, 2'b00, ~a);
  endtask
  task automatic t_regs();
    wr(10'h210, 8'h85);
    rd(10'h210, 8'h85);
    for (int s = 0; s < 4; s++) begin
      wr(10'h212, 8'(s * 4 + 3));
      rd(10'h212, 8'(s * 4 + 16));
    end
    rd(10'h211, 8'hff);
  endtask
  task automatic t_win();
    wr(10'h212, 8'h04);
    wr(10'h210, 8'h85);
    acc(2'b10, 20'hd1abc, {3'b110, 2'b11, 7'h05});
    acc(2'b01, 20'hd0000, {3'b110, 2'b10, 7'h05});
    wr(10'h210, 8'h7f);
    acc(2'b10, 20'hd1fff, {3'b110, 2'b01, 7'h7f});
    acc(2'b10, 20'he0000, {3'b111, 2'b11, 7'h7f});
    for (int s = 0; s < 4; s++) begin
      wr(10'h212, 8'(s * 4));
      acc(2'b01, 20'hd0155, {~3'(s ? 1 << (s - 1) : 0), 1'b1, 1'b0, 7'h7f});
    end
  endtask
  // mid-run reset must clear both registers and park the socket pins
  task automatic t_rst();
    h.go(2'b00, 10'h0, 8'h0, 2'b00, 20'h0);
    sys_rst_in = 1;
    repeat (3) @(negedge core_clk_in);
    `CHK({sock_out.socket_sel_n, sock_out.write_n, sock_out.read_n, sock_out.bank_field_bits}, 12'hf80)
    `CHK(io_rdata_out, 8'h00)
    sys_rst_in = 0;
    rd(10'h210, 8'h00);
    rd(10'h212, 8'h10);
  endtask
  // host-built bank patterns reach the socket unchanged
  task automatic t_pat();
    wr(10'h212, 8'h08);
    wr(10'h210, 8'h1a);
    acc(2'b01, 20'hd0000, {3'b101, 2'b10, 7'h1a});
    wr(10'h210, 8'h65);
    acc(2'b10, 20'hd1000, {3'b101, 2'b01, 7'h65});
    wr(10'h210, 8'h29);
    acc(2'b01, 20'hd0042, {3'b101, 2'b10, 7'h29});
  endtask
  task automatic end_sim();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // a hang is cut well past the seventy cycles of stimulus
  always @(posedge core_clk_in) begin
    n <= n + 1;
    if (n == 2000) begin
      fails++;
      end_sim();
    end
  end
  initial begin
    h.go(2'b00, 10'h0, 8'h0, 2'b00, 20'h0);
    repeat (11) @(negedge core_clk_in);
    sys_rst_in = 0;
    t_regs();
    t_win();
    t_rst();
    t_pat();
    end_sim();
  end
endmodule
`default_nettype wire
